//--- dv/host_model.sv
/*
 Host side of the load switch: drives the enable pin and reads the fault flag.
 Assumes an external pull-up on the open-drain flag line.
*/
`timescale 1ns/1ps
module host_model (
    input wire logic want_on_in,
    input wire logic active_low_in,
    input wire logic fault_flag_in,
    input wire logic fault_flag_oe_n_in,
    output logic enable_pin_out,
    output logic flag_line_out
);
    // Toggling want_on_in is how a latched fault is cleared
    assign enable_pin_out = want_on_in ^ active_low_in;
    // Released flag reads high through the pull-up
    assign flag_line_out = fault_flag_oe_n_in ? 1'b1 : fault_flag_in;
endmodule : host_model

//--- dv/load_switch_fault_sequencer_test.sv
/*
 Self-checking bench for the load switch fault sequencer.
 Assumes shortened intervals of 20 and 640 cycles, ratio kept at 32.
*/
`timescale 1ns/1ps
module load_switch_fault_sequencer_test;
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, want_on = 1'b0, active_low = 1'b0;
    logic oc = 1'b0, fwd = 1'b0, open_pin = 1'b0, rev = 1'b0, hot = 1'b0, gnd = 1'b0;
    logic [1:0] policy = 2'h0;
    logic en_pin, sw, fdat, foe_n, flag_line;
    int n_mismatch = 0;
    int check_count = 0;
    // ***********************************
    // Design and host
    // ***********************************
    load_switch_fault_sequencer #(.QUALIFY_CYCLES(25'h00_0014), .OFF_WAIT_CYCLES(25'h00_0280)) i_dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .enable_pin_in(en_pin),
        .enable_active_low_in(active_low), .policy_in(policy), .over_current_in(oc),
        .forward_current_in(fwd), .limit_set_pin_open_in(open_pin), .reverse_current_in(rev),
        .over_temp_in(hot), .limit_set_pin_grounded_in(gnd), .switch_on_out(sw),
        .fault_flag_out(fdat), .fault_flag_oe_n_out(foe_n));
    host_model i_host (.want_on_in(want_on), .active_low_in(active_low), .fault_flag_in(fdat),
        .fault_flag_oe_n_in(foe_n), .enable_pin_out(en_pin), .flag_line_out(flag_line));
    initial
    begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    // ***********************************
    // Shared tasks
    // ***********************************
    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic do_reset(input logic [1:0] p, input logic al, input logic op);
        @(negedge core_clk_in);
        rst_n_in = 1'b0;
        {policy, active_low, open_pin, want_on} = {p, al, op, 1'b1};
        {oc, fwd, rev, hot, gnd} = 5'h00;
        repeat (4) @(negedge core_clk_in);
        rst_n_in = 1'b1;
    endtask : do_reset
    // Bounded wait; an exhausted bound ends the run
    task automatic wait_val(input int w, input logic v, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(negedge core_clk_in);
            if ((w ? flag_line : sw) === v)
            begin
                check_count++;
                return;
            end
        end
        n_mismatch++;
        $display("ERROR %s expected %b seen %b", w ? "flag" : "switch", v, w ? flag_line : sw);
        finish_test();
    endtask : wait_val
    task automatic hold(input logic s, input logic f, input int n);
        check_count++;
        repeat (n)
        begin
            @(negedge core_clk_in);
            if (sw !== s || flag_line !== f)
            begin
                n_mismatch++;
                $display("ERROR switch_flag expected %b%b seen %b%b", s, f, sw, flag_line);
                return;
            end
        end
    endtask : hold
    // ***********************************
    // Scenarios
    // ***********************************
    task automatic t_polarity(input logic al);
        do_reset(2'h0, al, 1'b0);
        wait_val(0, 1'b1, 8);
        want_on = 1'b0;
        wait_val(0, 1'b0, 6);
        hold(1'b0, 1'b1, 10);
        want_on = 1'b1;
        wait_val(0, 1'b1, 6);
    endtask : t_polarity
    task automatic t_retry();
        do_reset(2'h0, 1'b0, 1'b0);
        wait_val(0, 1'b1, 8);
        oc = 1'b1;
        repeat (15) @(negedge core_clk_in);
        oc = 1'b0;
        repeat (3) @(negedge core_clk_in);
        oc = 1'b1;
        hold(1'b1, 1'b1, 20);
        wait_val(1, 1'b0, 10);
        // Two full off-wait cycles while the overcurrent stays asserted
        for (int k = 0; k < 2; k++)
        begin
            if (k > 0)
            begin
                hold(1'b1, 1'b0, 15);
                wait_val(0, 1'b0, 10);
            end
            hold(1'b0, 1'b0, 630);
            wait_val(0, 1'b1, 20);
        end
        hold(1'b1, 1'b0, 15);
        oc = 1'b0;
        wait_val(1, 1'b1, 30);
        hold(1'b1, 1'b1, 700);
    endtask : t_retry
    task automatic t_latch();
        do_reset(2'h1, 1'b0, 1'b0);
        wait_val(0, 1'b1, 8);
        oc = 1'b1;
        hold(1'b1, 1'b1, 20);
        wait_val(1, 1'b0, 10);
        oc = 1'b0;
        hold(1'b0, 1'b0, 700);
        want_on = 1'b0;
        repeat (4) @(negedge core_clk_in);
        want_on = 1'b1;
        wait_val(0, 1'b1, 8);
        wait_val(1, 1'b1, 5);
    endtask : t_latch
    task automatic t_cont(input logic op);
        do_reset(2'h2, 1'b0, op);
        wait_val(0, 1'b1, 8);
        // Programmed limit: forward current alone is no overcurrent
        fwd = !op;
        hold(1'b1, 1'b1, 30);
        if (op)
            fwd = 1'b1;
        else
            oc = 1'b1;
        hold(1'b1, 1'b1, 20);
        wait_val(1, 1'b0, 10);
        hold(1'b1, 1'b0, 50);
        {oc, fwd} = 2'h0;
        wait_val(1, 1'b1, 6);
    endtask : t_cont
    task automatic t_hard();
        do_reset(2'h0, 1'b0, 1'b0);
        wait_val(0, 1'b1, 8);
        for (int k = 0; k < 3; k++)
        begin
            {rev, hot, gnd} = 3'h4 >> k;
            wait_val(1, 1'b0, 4);
            hold(1'b0, 1'b0, 20);
            {rev, hot, gnd} = 3'h0;
            wait_val(1, 1'b1, 5);
            wait_val(0, 1'b1, 5);
        end
        {rev, hot} = 2'h3;
        wait_val(1, 1'b0, 4);
        rev = 1'b0;
        hold(1'b0, 1'b0, 10);
        hot = 1'b0;
        wait_val(1, 1'b1, 5);
    endtask : t_hard
    initial
    begin
        t_polarity(1'b0);
        t_polarity(1'b1);
        t_retry();
        t_latch();
        t_cont(1'b0);
        t_cont(1'b1);
        t_hard();
        finish_test();
    end
endmodule : load_switch_fault_sequencer_test

//--- logic/load_switch_fault_sequencer.sv
/*
 Fault sequencer of a current-limit load switch: comparator levels in,
 switch gate and open-drain fault flag out.
 Assumes comparator levels are asynchronous and the variant pins are static.
*/
// Notes on behaviour
// - Overcurrent for a full blanking interval asserts the fault flag.
// - Overcurrent clearing early resets blanking timer, no flag, no switch change.
// - Autoretry: after blanking, switch off for retry interval, then retry.
// - Autoretry: flag stays low through repeating blanking and retry cycles.
// - Autoretry: no overcurrent after retry leaves switch on, cycling stops.
// - Latch-off: switch off and held off after qualified overcurrent, flag low.
// - Enable toggle clears the latch and re-enables the switch.
// - Continuous: switch stays on, flag after blanking, flag off when overload ends.
// - Enable polarity follows variant; active-low variant inverts it.
// - Reverse current turns switch off and flags immediately, no blanking.
// - Reverse current clearing restores switch and releases flag.
// - Over-temperature turns switch off and flags; restore when it clears.
// - Flag low while any fault cause holds; a qualified overcurrent keeps it low until the sequencer is back in idle.
// - Open limit pin means zero threshold; any forward current is overcurrent.
// - Retry interval is exactly 32 blanking intervals from one timebase.
// - Grounded limit pin forces switch off and flag, whatever enable says.
`timescale 1ns/1ps
`include "fault_seq_regs.svh"
module load_switch_fault_sequencer #(
    parameter logic [24:0] QUALIFY_CYCLES = 25'(`QUALIFY_CYCLES),
    parameter logic [24:0] OFF_WAIT_CYCLES = 25'(`OFF_WAIT_CYCLES)
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic enable_pin_in,
    input wire logic enable_active_low_in,
    input wire logic [1:0] policy_in,
    input wire logic over_current_in,
    input wire logic forward_current_in,
    input wire logic limit_set_pin_open_in,
    input wire logic reverse_current_in,
    input wire logic over_temp_in,
    input wire logic limit_set_pin_grounded_in,
    output logic switch_on_out,
    output logic fault_flag_out,
    output logic fault_flag_oe_n_out
);
    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [`SYNC_W-1:0] raw;
    logic [`SYNC_W-1:0] sync;
    // Straps ride the same flops as the enable pin, so polarity and level arrive together
    assign raw = {policy_in, limit_set_pin_open_in, enable_active_low_in, enable_pin_in, over_current_in,
                  forward_current_in, reverse_current_in, over_temp_in, limit_set_pin_grounded_in};
    pin_sync #(.W(`SYNC_W)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(raw),
        .sync_out(sync)
    );

    logic [1:0] policy_s;
    logic open_s;
    logic al_s;
    logic en_pin_s;
    logic oc_raw_s;
    logic fwd_s;
    logic rev_s;
    logic hot_s;
    logic gnd_s;
    assign {policy_s, open_s, al_s, en_pin_s, oc_raw_s, fwd_s, rev_s, hot_s, gnd_s} = sync;

    logic enable_req;
    logic overcurrent;
    logic hard_fault;
    // Both bits clear in reset, so no false enable for the active-low variant
    assign enable_req = en_pin_s ^ al_s;
    // Open pin: zero threshold, so any forward current qualifies
    assign overcurrent = open_s ? fwd_s : oc_raw_s;
    assign hard_fault = rev_s | hot_s | gnd_s;

    // ****************************************************************
    // Enable edge detection for the enable-rise check (latch release uses the enable level)
    // ****************************************************************
    logic enable_q;
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
            enable_q <= 1'b0;
        else
            enable_q <= enable_req;
    end

    // ****************************************************************
    // Overcurrent state machine
    // ****************************************************************
    fault_seq_pkg::oc_state_e state_q;
    fault_seq_pkg::oc_state_e state_d;
    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;
    logic flag_hold_q;
    logic flag_hold_d;

    function automatic logic [`CNT_W-1:0] cnt_next(input logic [`CNT_W-1:0] c);
        cnt_next = c + `CNT_W'(1);
    endfunction : cnt_next

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        flag_hold_d = flag_hold_q;
        case (state_q)
            fault_seq_pkg::ST_IDLE:
            begin
                cnt_d = '0;
                flag_hold_d = 1'b0;
                if (enable_req && !hard_fault && overcurrent)
                begin
                    state_d = fault_seq_pkg::ST_QUALIFY;
                    cnt_d = `CNT_W'(1);
                end
            end
            fault_seq_pkg::ST_QUALIFY:
            begin
                if (!enable_req || hard_fault || !overcurrent)
                begin
                    // Early clear: no flag, no switch change
                    state_d = fault_seq_pkg::ST_IDLE;
                    cnt_d = '0;
                    flag_hold_d = 1'b0;
                end
                else if (cnt_q >= QUALIFY_CYCLES)
                begin
                    flag_hold_d = 1'b1;
                    cnt_d = '0;
                    case (policy_s)
                        `POLICY_RETRY: state_d = fault_seq_pkg::ST_OFF_WAIT;
                        `POLICY_LATCH: state_d = fault_seq_pkg::ST_LATCHED;
                        default: cnt_d = cnt_q; // Continuous: keep limiting
                    endcase
                end
                else
                    cnt_d = cnt_next(cnt_q);
            end
            fault_seq_pkg::ST_OFF_WAIT:
            begin
                if (!enable_req)
                begin
                    state_d = fault_seq_pkg::ST_IDLE;
                    cnt_d = '0;
                    flag_hold_d = 1'b0;
                end
                else if (cnt_q >= OFF_WAIT_CYCLES - `CNT_W'(1))
                begin
                    // Retry: switch back on, flag kept low; count from one as from idle,
                    // so every blanking run is equally long
                    state_d = fault_seq_pkg::ST_QUALIFY;
                    cnt_d = `CNT_W'(1);
                end
                else
                    cnt_d = cnt_next(cnt_q);
            end
            fault_seq_pkg::ST_LATCHED:
            begin
                if (!enable_req)
                begin
                    state_d = fault_seq_pkg::ST_IDLE;
                    flag_hold_d = 1'b0;
                end
            end
            default:
            begin
                state_d = fault_seq_pkg::ST_IDLE;
                cnt_d = '0;
                flag_hold_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= fault_seq_pkg::ST_IDLE;
            cnt_q <= '0;
            flag_hold_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flag_hold_q <= flag_hold_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic switch_d;
    logic flag_d;
    assign switch_d = enable_req && !hard_fault &&
                      state_d != fault_seq_pkg::ST_OFF_WAIT &&
                      state_d != fault_seq_pkg::ST_LATCHED;
    assign flag_d = flag_hold_d || hard_fault;

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            switch_on_out <= 1'b0;
            fault_flag_out <= 1'b1;
            fault_flag_oe_n_out <= 1'b1;
        end
        else
        begin
            switch_on_out <= switch_d;
            // Open drain: drive low only, oe low while driving
            fault_flag_out <= 1'b0;
            fault_flag_oe_n_out <= !flag_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_hard_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        hard_fault |=> !switch_on_out && !fault_flag_oe_n_out)
        else $error("hard fault did not force off and flag");
    a_enable_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !enable_req |=> !switch_on_out)
        else $error("switch on while enable off");
    a_early_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state_q == fault_seq_pkg::ST_QUALIFY && !overcurrent && !hard_fault && enable_req
        |=> state_q == fault_seq_pkg::ST_IDLE && cnt_q == '0)
        else $error("blanking timer not reset");
    a_latch_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state_q == fault_seq_pkg::ST_LATCHED && enable_req |=> !switch_on_out)
        else $error("latched switch turned on");
    a_latch_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state_q == fault_seq_pkg::ST_LATCHED && !enable_req |=> state_q == fault_seq_pkg::ST_IDLE)
        else $error("latch not cleared by enable toggle");
    a_enable_rise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !enable_q && enable_req && !hard_fault && state_q == fault_seq_pkg::ST_IDLE |=> switch_on_out)
        else $error("switch not on after enable toggle");
    a_retry_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        state_q == fault_seq_pkg::ST_OFF_WAIT && enable_req |=> !fault_flag_oe_n_out)
        else $error("flag released during off wait");
    a_qualify_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(flag_hold_q) |-> $past(state_q) == fault_seq_pkg::ST_QUALIFY
        && $past(cnt_q) >= QUALIFY_CYCLES)
        else $error("flag before blanking expired");
    a_cont_on: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        policy_s == `POLICY_CONT && enable_req && !hard_fault |=> switch_on_out)
        else $error("continuous variant switched off");
    a_flag_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !hard_fault && state_q == fault_seq_pkg::ST_IDLE && !flag_hold_q
        ##0 state_d == fault_seq_pkg::ST_IDLE |=> fault_flag_oe_n_out)
        else $error("flag held without cause");
endmodule : load_switch_fault_sequencer

//--- logic/pin_sync.sv
/*
 Two-flop synchroniser for a bundle of asynchronous levels.
 Assumes a single clock; output only from the second flop.
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 6
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync

//--- pkg/fault_seq_pkg.sv
/*
 Types for the load switch fault sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fault_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_QUALIFY = 4'b0010,
        ST_OFF_WAIT = 4'b0100,
        ST_LATCHED = 4'b1000
    } oc_state_e;
endpackage : fault_seq_pkg

//--- pkg/fault_seq_regs.svh
/*
 Timing and encoding constants for the load switch fault sequencer.
 Assumes a 20 MHz core clock; included by bare name.
*/
`ifndef FAULT_SEQ_REGS_SVH
`define FAULT_SEQ_REGS_SVH
// Core clock period in picoseconds (50 ns)
`define CLK_PERIOD_PS 64'd50000
// Blanking interval in microseconds (17.5 ms)
`define QUALIFY_US 64'd17500
// Off-wait is a fixed multiple of the blanking interval
`define OFF_WAIT_RATIO 32'd32
// Blanking interval in clock cycles: 17.5 ms / 50 ns
`define QUALIFY_CYCLES ((`QUALIFY_US * 64'd1000000) / `CLK_PERIOD_PS)
// Off-wait interval, 560 ms, in clock cycles
`define OFF_WAIT_CYCLES (`QUALIFY_CYCLES * 64'(`OFF_WAIT_RATIO))
`define CNT_W 25
// Synchronised bundle: policy, open pin, polarity, enable, five comparators
`define SYNC_W 10
// Policy codes
`define POLICY_RETRY 2'h0
`define POLICY_LATCH 2'h1
`define POLICY_CONT 2'h2
`endif
